// ==== iff_fetch.sv ====
// Instruction fetch front end: octet prefetch, two instruction files, holding register.
// Notes on behaviour
// RULE_01 - Four address registers, one for branch targets.
// RULE_02 - Request next octet while current drains.
// RULE_03 - Two instruction files, one octet each.
// RULE_04 - Fill one file, drain it, fill other.
// RULE_05 - Indirect address resident in files selected directly.
// RULE_06 - Output address register steps through indirect chain.
// RULE_07 - Program address held during indirect chain.
// RULE_08 - Register file of six octets, 32-bit.
// RULE_09 - Partitions: base, arithmetic, index, vector parameter.
// RULE_10 - File writes from memory or arithmetic unit.
// RULE_11 - Holding register captures and holds selected word.
// RULE_12 - Level advances unless reserved by earlier one.
// RULE_13 - Word: opcode, R, T, M, N fields.
// RULE_14 - 21-bit octet, 24-bit word addresses.
// RULE_15 - Low three bits select word in octet.
// RULE_16 - File valid only after full octet.
module iff_fetch
    import iff_pkg::*;
(
    // Clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          resetn,
    // Memory side
    output iff_pkg::iff_mem_req_t              mem_req,
    input  wire logic                          mem_req_ready,
    input  wire iff_pkg::iff_mem_word_t        mem_word,
    // Decode level handshake
    output iff_pkg::iff_instr_t                instr,
    output logic                               instr_valid,
    input  wire logic                          level1_busy,
    // Branch and indirect control
    input  wire logic                          branch_valid,
    input  wire logic [iff_pkg::WADDR_W-1:0]   branch_addr,
    input  wire logic                          indir_valid,
    input  wire logic                          indir_last,
    input  wire logic [iff_pkg::WADDR_W-1:0]   indir_addr,
    output logic                               indir_busy,
    // Register file port
    input  wire iff_pkg::iff_rf_wr_t           rf_wr,
    input  wire logic [iff_pkg::WORD_W-1:0]    rf_mem_data,
    input  wire logic [iff_pkg::WORD_W-1:0]    rf_arith_data,
    input  wire logic [iff_pkg::RF_IDX_W-1:0]  rf_rd_idx,
    output logic      [iff_pkg::WORD_W-1:0]    rf_rd_data
);
    import iff_pkg::*;

    typedef enum logic [1:0] {IFF_SEQ, IFF_IND, IFF_IND_WAIT} iff_mode_t;

    // RULE_15 - word and octet split
    function automatic logic [OADDR_W-1:0] octet_of(input logic [WADDR_W-1:0] a);
        octet_of = a[WADDR_W-1:SEL_W];
    endfunction : octet_of

    // RULE_01 - four address registers
    logic [WADDR_W-1:0] present_addr_ff;   // Word being issued.
    logic [WADDR_W-1:0] look_ahead_ff;     // Next octet to prefetch (octet aligned).
    logic [WADDR_W-1:0] branch_addr_ff;    // Captured branch target.
    logic [WADDR_W-1:0] out_addr_ff;       // Address sent to memory / indirect pointer.

    // RULE_03 - two octet files
    logic [WORD_W-1:0]  file_ff [2][OCT_WORDS];
    logic [OADDR_W-1:0] file_tag_ff [2];
    logic [1:0]         file_valid_ff;
    logic [OCT_WORDS-1:0] fill_mask_ff;
    logic               fill_busy_ff;
    logic               fill_sel_ff;
    logic               req_ff;
    iff_mode_t          mode_ff;
    logic               chain_busy_ff;     // Registered copy of the chain state.
    iff_instr_t         instr_ff;
    logic               instr_valid_ff;

    // Lookup of a word address in either file.
    wire [OADDR_W-1:0] pa_oct  = octet_of(present_addr_ff);
    wire [OADDR_W-1:0] oa_oct  = octet_of(out_addr_ff);
    wire [OADDR_W-1:0] la_oct  = octet_of(look_ahead_ff);
    wire               pa_hit0 = file_valid_ff[0] && (file_tag_ff[0] == pa_oct);
    wire               pa_hit1 = file_valid_ff[1] && (file_tag_ff[1] == pa_oct);
    wire               oa_hit0 = file_valid_ff[0] && (file_tag_ff[0] == oa_oct);
    wire               oa_hit1 = file_valid_ff[1] && (file_tag_ff[1] == oa_oct);
    wire               la_have = (file_valid_ff[0] && file_tag_ff[0] == la_oct)
                               || (file_valid_ff[1] && file_tag_ff[1] == la_oct);
    wire               ind_mode = (mode_ff != IFF_SEQ);
    wire [WADDR_W-1:0] sel_addr = ind_mode ? out_addr_ff : present_addr_ff;
    // RULE_16 - issue from valid file
    wire               sel_hit  = ind_mode ? (oa_hit0 || oa_hit1) : (pa_hit0 || pa_hit1);
    wire               sel_file = ind_mode ? oa_hit1 : pa_hit1;
    wire [WORD_W-1:0]  sel_word = file_ff[sel_file][sel_addr[SEL_W-1:0]];
    // RULE_12 - stall while reserved
    // An indirect start owns its cycle, so the present word is never issued twice.
    wire               issue    = sel_hit && !level1_busy && !branch_valid && !indir_valid
                               && (mode_ff != IFF_IND_WAIT);
    // RULE_04 - refill file not in use
    wire               fill_tgt = pa_hit0 ? 1'b1 : 1'b0;
    // RULE_05 - indirect miss needs fetch
    wire               ind_miss = ind_mode && !(oa_hit0 || oa_hit1);
    // RULE_02 - prefetch while draining
    wire               want_req = !fill_busy_ff && !req_ff
                               && (ind_miss || !la_have || !(pa_hit0 || pa_hit1));
    wire [WADDR_W-1:0] req_word = ind_miss ? out_addr_ff
                               : ((pa_hit0 || pa_hit1) ? look_ahead_ff : present_addr_ff);
    wire               req_done = req_ff && mem_req_ready;
    wire               last_in  = mem_word.valid
                               && ((fill_mask_ff | (8'h01 << mem_word.word_idx)) == 8'hFF);
    logic [OADDR_W-1:0] req_oct_ff;

    // Request register: holds the octet address until memory accepts it.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            req_ff     <= 1'b0;
            req_oct_ff <= '0;
        end else if (want_req) begin
            req_ff     <= 1'b1;
            // RULE_14 - 21-bit octet address
            req_oct_ff <= octet_of(req_word);
        end else if (req_done) begin
            req_ff     <= 1'b0;
        end
    end

    // Fill tracking. A branch does not cancel a fill in flight; the octet
    // simply lands under the tag set when memory accepted it, which is cheaper than a flush.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            fill_busy_ff  <= 1'b0;
            fill_sel_ff   <= 1'b0;
            fill_mask_ff  <= '0;
            file_valid_ff <= '0;
            file_tag_ff[0] <= '0;
            file_tag_ff[1] <= '0;
        end else if (req_done) begin
            fill_busy_ff  <= 1'b1;
            fill_sel_ff   <= fill_tgt;
            fill_mask_ff  <= '0;
            file_valid_ff[fill_tgt] <= 1'b0;
            file_tag_ff[fill_tgt]   <= req_oct_ff;
        end else if (fill_busy_ff && mem_word.valid) begin
            fill_mask_ff <= fill_mask_ff | (8'h01 << mem_word.word_idx);
            // RULE_16 - valid on full octet
            if (last_in) begin
                file_valid_ff[fill_sel_ff] <= 1'b1;
                fill_busy_ff               <= 1'b0;
            end
        end
    end

    // Word storage for both files.
    always_ff @(posedge ref_clk) begin
        if (fill_busy_ff && mem_word.valid) begin
            file_ff[fill_sel_ff][mem_word.word_idx] <= mem_word.data;
        end
    end

    // Address registers and indirect sequencing.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            present_addr_ff <= START_ADDR;
            look_ahead_ff   <= START_ADDR + 24'h000008;
            branch_addr_ff  <= START_ADDR;
            out_addr_ff     <= START_ADDR;
            mode_ff         <= IFF_SEQ;
            chain_busy_ff   <= 1'b0;
        end else if (branch_valid) begin
            branch_addr_ff  <= branch_addr;
            present_addr_ff <= branch_addr;
            look_ahead_ff   <= {branch_addr[WADDR_W-1:SEL_W] + 21'h000001, 3'h0};
            mode_ff         <= IFF_SEQ;
            chain_busy_ff   <= 1'b0;
        end else begin
            unique case (mode_ff)
                IFF_SEQ: begin
                    if (indir_valid) begin
                        // RULE_06 - load first modifier address
                        out_addr_ff   <= indir_addr;
                        mode_ff       <= indir_last ? IFF_SEQ : IFF_IND;
                        chain_busy_ff <= !indir_last;
                    end else if (issue) begin
                        present_addr_ff <= present_addr_ff + 24'h000001;
                        if (la_oct == pa_oct) begin
                            look_ahead_ff <= look_ahead_ff + 24'h000008;
                        end
                    end else if (la_oct == pa_oct) begin
                        look_ahead_ff <= look_ahead_ff + 24'h000008;
                    end
                end
                IFF_IND: begin
                    // RULE_07 - program address held
                    if (issue) begin
                        mode_ff <= IFF_IND_WAIT;
                    end
                end
                IFF_IND_WAIT: begin
                    // RULE_06 - step to next address
                    if (indir_valid) begin
                        out_addr_ff   <= indir_addr;
                        mode_ff       <= indir_last ? IFF_SEQ : IFF_IND;
                        chain_busy_ff <= !indir_last;
                    end
                end
            endcase
        end
    end

    // RULE_11 - capture and hold word
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            instr_ff       <= '0;
            instr_valid_ff <= 1'b0;
        end else if (issue) begin
            // RULE_13 - field layout via struct
            instr_ff       <= iff_instr_t'(sel_word);
            instr_valid_ff <= 1'b1;
        end else if (!level1_busy) begin
            instr_valid_ff <= 1'b0;
        end
    end

    // Outputs are registered copies.
    assign mem_req.valid      = req_ff;
    assign mem_req.octet_addr = req_oct_ff;
    assign instr              = instr_ff;
    assign instr_valid        = instr_valid_ff;
    assign indir_busy         = chain_busy_ff;

    // RULE_09 - partitioned register file
    iff_regfile #(
        .ENTRIES (RF_ENTRIES)
    ) u_regfile (
        .ref_clk    (ref_clk),
        .resetn     (resetn),
        .wr         (rf_wr),
        .mem_data   (rf_mem_data),
        .arith_data (rf_arith_data),
        .rd_idx     (rf_rd_idx),
        .rd_data    (rf_rd_data)
    );

    // Assertions.
    property p_hold_pa;
        @(posedge ref_clk) disable iff (!resetn)
        (ind_mode && !branch_valid) |=> $stable(present_addr_ff);
    endproperty
    a_hold_pa: assert property (p_hold_pa) else $error("program address moved in chain"); // RULE_07

    property p_oa_load;
        @(posedge ref_clk) disable iff (!resetn)
        (indir_valid && !branch_valid && mode_ff != IFF_IND) |=> (out_addr_ff == $past(indir_addr));
    endproperty
    a_oa_load: assert property (p_oa_load) else $error("output address not loaded"); // RULE_06

    property p_issue_valid;
        @(posedge ref_clk) disable iff (!resetn)
        issue |-> (file_valid_ff[sel_file]);
    endproperty
    a_issue_valid: assert property (p_issue_valid) else $error("issue from invalid file"); // RULE_16

    property p_ir_capture;
        @(posedge ref_clk) disable iff (!resetn)
        issue |=> (instr_valid && instr == iff_instr_t'($past(sel_word)));
    endproperty
    a_ir_capture: assert property (p_ir_capture) else $error("word not captured"); // RULE_11

    property p_ir_hold;
        @(posedge ref_clk) disable iff (!resetn)
        level1_busy |=> $stable(instr);
    endproperty
    a_ir_hold: assert property (p_ir_hold) else $error("holding register changed while busy"); // RULE_12

    property p_chain_flag;
        @(posedge ref_clk) disable iff (!resetn)
        chain_busy_ff == ind_mode;
    endproperty
    a_chain_flag: assert property (p_chain_flag) else $error("chain flag disagrees with mode"); // RULE_07

    property p_req_hold;
        @(posedge ref_clk) disable iff (!resetn)
        (mem_req.valid && !mem_req_ready) |=> (mem_req.valid && $stable(mem_req.octet_addr));
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped before accept"); // RULE_14

    property p_fill_valid;
        @(posedge ref_clk) disable iff (!resetn)
        (fill_busy_ff && last_in) |=> file_valid_ff[$past(fill_sel_ff)];
    endproperty
    a_fill_valid: assert property (p_fill_valid) else $error("file not marked valid"); // RULE_04

    property p_fill_other;
        @(posedge ref_clk) disable iff (!resetn)
        (req_done && !ind_mode && (pa_hit0 || pa_hit1)) |-> (fill_tgt != pa_hit1);
    endproperty
    a_fill_other: assert property (p_fill_other) else $error("refill hit active file"); // RULE_02

    c_issue:  cover property (@(posedge ref_clk) disable iff (!resetn) issue ##1 issue);
    c_chain:  cover property (@(posedge ref_clk) disable iff (!resetn) mode_ff == IFF_IND ##[1:20] mode_ff == IFF_SEQ);
    c_branch: cover property (@(posedge ref_clk) disable iff (!resetn) branch_valid ##[1:40] issue);
endmodule : iff_fetch

// ==== iff_fetch_tb.sv ====
// Self-checking bench: program stream, branches, indirect chain, register file.
module iff_fetch_tb
    import iff_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic               ref_clk = 1'h0, resetn = 1'h0, slow = 1'h0, rnd_busy = 1'h1;
    logic               level1_busy = 1'h0, branch_valid = 1'h0;
    logic               indir_valid = 1'h0, indir_last = 1'h0;
    logic               instr_valid, indir_busy, mem_req_ready;
    iff_mem_req_t       mem_req;
    iff_mem_word_t      mem_word;
    iff_instr_t         instr, hold_w;
    iff_rf_wr_t         rf_wr = '0;
    logic [WADDR_W-1:0] branch_addr = '0, indir_addr = '0, exp_pc = START_ADDR;
    logic [WADDR_W-1:0] ind_a, s_tgt, s_ia;
    logic [WORD_W-1:0]  rf_mem_data = '0, rf_arith_data = '0, rf_rd_data, rf_exp [RF_ENTRIES];
    logic [5:0]         rf_rd_idx = '0;
    logic [OADDR_W-1:0] last_req = '0, watch_oct = '0;
    logic [31:0]        seed = 32'h0FA1;
    logic               s_busy, s_br, s_ind, s_last;
    logic               ind_on = 1'h0, ind_end = 1'h0, watch_hit = 1'h0, seq_prev = 1'h0;
    int                 n_mismatch = 0, comparisons = 0, n_iss = 0, n_ind = 0;

    // Free-running 125 MHz clock.
    always #4 ref_clk = ~ref_clk;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    // Memory content rule: each word encodes its own address.
    function automatic iff_instr_t exp_word(input logic [WADDR_W-1:0] a);
        return iff_instr_t'({a[7:0] ^ 8'hC3, a});
    endfunction : exp_word

    task automatic chk_instr(input string what, input iff_instr_t e, input iff_instr_t g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : chk_instr

    task automatic chk_data(input string what, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : chk_data

    task automatic chk_flag(input string what, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %b seen %b", what, e, g);
        end
    endtask : chk_flag

    task automatic results();
        $display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    // A bounded wait that runs out is a failure of its own.
    task automatic give_up(input string what);
        n_mismatch++;
        $display("ERROR %s expected done seen stuck", what);
        results();
    endtask : give_up

    task automatic run(input int n);
        int goal;
        int t;
        goal = n_iss + n;
        for (t = 0; t < 3000 && n_iss < goal; t++) @(negedge ref_clk);
        if (n_iss < goal) give_up("issue count");
    endtask : run

    // Entered and left with the decode level held busy, so no stray issue slips in.
    task automatic ind_step(input logic [WADDR_W-1:0] a, input logic last);
        int goal;
        int t;
        goal = n_ind + 1;
        @(posedge ref_clk);
        indir_valid <= 1'h1;
        indir_addr <= a;
        indir_last <= last;
        @(posedge ref_clk);
        indir_valid <= 1'h0;
        indir_last <= 1'h0;
        level1_busy <= last;
        for (t = 0; t < 400 && (last ? indir_busy !== 1'h0 : n_ind < goal); t++) @(negedge ref_clk);
        if (t == 400) give_up("indirect step");
        @(posedge ref_clk);
        level1_busy <= 1'h1;
    endtask : ind_step

    iff_fetch dut_u (.ref_clk(ref_clk), .resetn(resetn), .mem_req(mem_req),
        .mem_req_ready(mem_req_ready), .mem_word(mem_word), .instr(instr),
        .instr_valid(instr_valid), .level1_busy(level1_busy), .branch_valid(branch_valid),
        .branch_addr(branch_addr), .indir_valid(indir_valid), .indir_last(indir_last),
        .indir_addr(indir_addr), .indir_busy(indir_busy), .rf_wr(rf_wr),
        .rf_mem_data(rf_mem_data), .rf_arith_data(rf_arith_data), .rf_rd_idx(rf_rd_idx),
        .rf_rd_data(rf_rd_data));

    iff_mem_model mem_u (.ref_clk(ref_clk), .resetn(resetn), .slow(slow), .mem_req(mem_req),
        .mem_req_ready(mem_req_ready), .mem_word(mem_word));

    // Record what each edge sampled, and draw random decode stalls.
    always @(posedge ref_clk) begin
        s_busy = level1_busy;
        s_br = branch_valid;
        s_tgt = branch_addr;
        s_ind = indir_valid;
        s_last = indir_last;
        s_ia = indir_addr;
        if (mem_req.valid) last_req = mem_req.octet_addr;
        if (mem_req.valid && mem_req.octet_addr == watch_oct) watch_hit = 1'h1;
        if (rnd_busy) level1_busy <= (xs() % 4 == 0);
    end

    // Judge each issue against the expected program or chain stream.
    always @(negedge ref_clk) begin
        if (resetn) begin
            if (s_ind) begin
                ind_on = 1'h1;
                ind_end = s_last;
                ind_a = s_ia;
            end
            if (s_br) begin
                exp_pc = s_tgt;
                seq_prev = 1'h0;
            end else if (s_busy && instr_valid) begin
                chk_instr("held word", hold_w, instr);
            end else if (instr_valid) begin
                n_iss++;
                hold_w = instr;
                if (ind_on) begin
                    chk_instr("pointer word", exp_word(ind_a), instr);
                    chk_flag("chain busy", 1'h1, indir_busy);
                    n_ind++;
                    seq_prev = 1'h0;
                end else begin
                    chk_instr("issued word", exp_word(exp_pc), instr);
                    if (exp_pc[2:0] == 3'h7 && seq_prev)
                        chk_data("next octet", 32'(exp_pc[23:3] + 21'h1), 32'(last_req));
                    seq_prev = 1'h1;
                    exp_pc = exp_pc + 24'h1;
                end
            end
            if (ind_end && indir_busy === 1'h0) begin
                ind_on = 1'h0;
                ind_end = 1'h0;
            end
        end
    end

    initial begin
        repeat (60000) @(posedge ref_clk);
        give_up("whole run");
    end

    initial begin
        logic [31:0] r;
        logic [WADDR_W-1:0] a;
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk);
        chk_flag("reset request", 1'h0, mem_req.valid);
        chk_flag("reset issue", 1'h0, instr_valid);
        chk_flag("reset chain", 1'h0, indir_busy);
        repeat (10) @(posedge ref_clk);
        resetn <= 1'h1;
        run(24);
        $display("test sequential done");
        @(posedge ref_clk);
        slow <= 1'h1;
        run(24);
        @(posedge ref_clk);
        slow <= 1'h0;
        $display("test slow memory done");
        for (int k = 0; k < 4; k++) begin
            r = xs();
            a = (k == 0) ? {r[23:3], 3'h7} : (k == 1) ? {r[23:3], 3'h0} : r[23:0];
            @(posedge ref_clk);
            branch_valid <= 1'h1;
            branch_addr <= a;
            @(posedge ref_clk);
            branch_valid <= 1'h0;
            run(12);
        end
        $display("test branch done");
        @(negedge ref_clk);
        rnd_busy = 1'h0;
        @(posedge ref_clk);
        level1_busy <= 1'h1;
        repeat (30) @(posedge ref_clk);
        @(negedge ref_clk);
        r = xs();
        watch_oct = exp_pc[23:3];
        watch_hit = 1'h0;
        ind_step({watch_oct, r[2:0]}, 1'h0);
        chk_flag("resident refetch", 1'h0, watch_hit);
        @(negedge ref_clk);
        watch_oct = watch_oct + 21'h40;
        watch_hit = 1'h0;
        ind_step({watch_oct, r[5:3]}, 1'h0);
        chk_flag("pointer fetch", 1'h1, watch_hit);
        ind_step(24'(xs()), 1'h1);
        // A terminal address taken straight from sequential issue leaves no chain.
        ind_step(24'(xs()), 1'h1);
        @(negedge ref_clk);
        rnd_busy = 1'h1;
        run(12);
        $display("test indirect chain done");
        for (int i = 0; i < RF_ENTRIES; i++) begin
            @(posedge ref_clk);
            r = xs();
            rf_wr <= '{1'h1, r[0], 6'(i)};
            rf_mem_data <= r;
            rf_arith_data <= ~r;
            rf_exp[i] = r[0] ? ~r : r;
        end
        @(posedge ref_clk);
        rf_wr <= '{1'h0, 1'h0, 6'h00};
        rf_mem_data <= 32'hFFFF_FFFF;
        for (int i = 0; i < RF_ENTRIES; i++) begin
            @(posedge ref_clk);
            rf_rd_idx <= 6'(i);
            @(posedge ref_clk);
            #1 chk_data("register read", rf_exp[i], rf_rd_data);
        end
        $display("test register file done");
        results();
    end
endmodule : iff_fetch_tb

// ==== iff_mem_model.sv ====
// Behavioural main memory that returns each instruction octet word by word.
module iff_mem_model
    import iff_pkg::*;
(
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  resetn,
    // Pace select
    input  wire logic                  slow,
    // Octet fetch port
    input  wire iff_pkg::iff_mem_req_t mem_req,
    output logic                       mem_req_ready,
    output iff_pkg::iff_mem_word_t     mem_word
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [OADDR_W-1:0] oct_ff;
    logic [3:0]         cnt_ff;
    logic               busy_ff;
    logic [31:0]        junk_ff;
    logic [2:0]         idx;
    logic [23:0]        wa;
    // Words leave out of order, so slot pairing in the fetch logic really matters.
    assign idx = cnt_ff[2:0] ^ 3'h5;
    assign wa = {oct_ff, idx};
    // One octet at a time; idle lines carry a changing pattern, never the last word.
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mem_req_ready <= 1'h0;
            mem_word <= '0;
            busy_ff <= 1'h0;
            cnt_ff <= 4'h0;
            oct_ff <= '0;
            junk_ff <= 32'h1357_9BDF;
        end else begin
            junk_ff <= {junk_ff[30:0], junk_ff[31] ^ junk_ff[21] ^ junk_ff[1] ^ junk_ff[0]};
            mem_req_ready <= mem_req.valid && !mem_req_ready && !busy_ff && (!slow || junk_ff[0]);
            if (mem_req.valid && mem_req_ready) begin
                mem_word <= '{1'h0, junk_ff[2:0], junk_ff};
                oct_ff <= mem_req.octet_addr;
                busy_ff <= 1'h1;
                cnt_ff <= 4'h0;
            end else if (busy_ff && (!slow || junk_ff[1])) begin
                mem_word <= '{1'h1, idx, {wa[7:0] ^ 8'hC3, wa}};
                cnt_ff <= cnt_ff + 4'h1;
                busy_ff <= (cnt_ff != 4'h7);
            end else begin
                mem_word <= '{1'h0, junk_ff[2:0], junk_ff};
            end
        end
    end
endmodule : iff_mem_model

// ==== iff_pkg.sv ====
// Shared constants and carrier types for the instruction fetch front end.
package iff_pkg;
    localparam int WORD_W      = 32;
    localparam int WADDR_W     = 24;
    localparam int OADDR_W     = 21;
    localparam int OCT_WORDS   = 8;
    localparam int SEL_W       = 3;
    localparam int RF_OCTETS   = 6;
    localparam int RF_IDX_W    = 6;
    localparam int RF_ENTRIES  = 48;
    // Register file partition start indices and sizes.
    localparam logic [5:0] RF_BASE_LO  = 6'h00;
    localparam int         RF_BASE_N   = 15;
    localparam logic [5:0] RF_ARITH_LO = 6'h10;
    localparam int         RF_ARITH_N  = 16;
    localparam logic [5:0] RF_INDEX_LO = 6'h21;
    localparam int         RF_INDEX_N  = 7;
    localparam logic [5:0] RF_VPAR_LO  = 6'h28;
    localparam int         RF_VPAR_N   = 8;
    localparam logic [WADDR_W-1:0] START_ADDR = 24'h000000;

    // Instruction word fields.
    typedef struct packed {
        logic [7:0]  opcode;
        logic [3:0]  r_fld;
        logic [3:0]  t_fld;
        logic [3:0]  m_fld;
        logic [11:0] n_fld;
    } iff_instr_t;

    // Octet request toward main memory.
    typedef struct packed {
        logic               valid;
        logic [OADDR_W-1:0] octet_addr;
    } iff_mem_req_t;

    // One returning word of an octet.
    typedef struct packed {
        logic              valid;
        logic [SEL_W-1:0]  word_idx;
        logic [WORD_W-1:0] data;
    } iff_mem_word_t;

    // Register file write request.
    typedef struct packed {
        logic                en;
        logic                from_arith;
        logic [RF_IDX_W-1:0] idx;
    } iff_rf_wr_t;
endpackage : iff_pkg

// ==== iff_regfile.sv ====
// Six-octet register file of 32-bit words inside the fetch front end.
module iff_regfile
    import iff_pkg::*;
#(
    parameter int ENTRIES = RF_ENTRIES
) (
    // Clock and reset
    input  wire logic                       ref_clk,
    input  wire logic                       resetn,
    // Write side
    input  wire iff_pkg::iff_rf_wr_t        wr,
    input  wire logic [iff_pkg::WORD_W-1:0] mem_data,
    input  wire logic [iff_pkg::WORD_W-1:0] arith_data,
    // Read side
    input  wire logic [iff_pkg::RF_IDX_W-1:0] rd_idx,
    output logic      [iff_pkg::WORD_W-1:0]   rd_data
);
    import iff_pkg::*;

    logic [WORD_W-1:0] mem_ff [ENTRIES];
    logic [WORD_W-1:0] wr_data;
    logic              wr_ok;

    // RULE_10 - source mux select
    assign wr_data = wr.from_arith ? arith_data : mem_data;
    // Out-of-range indices are dropped so the array never aliases.
    assign wr_ok   = wr.en && (int'(wr.idx) < ENTRIES);

    // RULE_08 - six octet storage
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < ENTRIES; i++) begin
                mem_ff[i] <= '0;
            end
        end else if (wr_ok) begin
            mem_ff[wr.idx] <= wr_data;
        end
    end

    // Registered read keeps the top-level outputs flop-driven.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rd_data <= '0;
        end else if (int'(rd_idx) < ENTRIES) begin
            rd_data <= mem_ff[rd_idx];
        end else begin
            rd_data <= '0;
        end
    end
endmodule : iff_regfile
